// ==== verilog/spx_alu_pkg.sv ====
package spx_alu_pkg;

  typedef enum logic [4:0] {
    sat_double_add_op,
    sat_double_sub_op,
    usat_add_sub_exchange_op,
    usat_sub_add_exchange_op,
    usat_dual_half_add_op,
    usat_quad_byte_add_op,
    usat_dual_half_sub_op,
    usat_quad_byte_sub_op,
    pack_low_high_op,
    pack_high_low_op,
    sign_ext_byte_op,
    zero_ext_byte_op,
    sign_ext_half_op,
    zero_ext_half_op,
    sign_ext_dual_byte_op,
    zero_ext_dual_byte_op,
    sign_ext_byte_acc_op,
    zero_ext_byte_acc_op,
    sign_ext_half_acc_op,
    zero_ext_half_acc_op,
    sign_ext_dual_byte_acc_op,
    zero_ext_dual_byte_acc_op
  } spx_op_type;

  localparam int SPX_WORD_W = 32;
  localparam logic [31:0] SPX_SMAX = 32'h7FFFFFFF;
  localparam logic [31:0] SPX_SMIN = 32'h80000000;
  localparam logic [31:0] SPX_RESULT_RST = 32'h00000000;
  localparam logic SPX_SAT_FLAG_RST = 1'b0;
  localparam int SPX_RESULT_LATENCY = 1;

endpackage

// ==== verilog/spx_alu.sv ====
`timescale 1ns/1ns
// Overview of operation
// - Double-add: saturated double of second, add first
// - Double-sub: saturated double subtracted from first
// - Both steps clamp to signed 32-bit range
// - Any clamp in double ops sets flag
// - Add-sub exchange: sum high, difference low
// - Sub-add exchange: difference high, sum low
// - Unsigned, pack, extend ops keep flags
// - Dual halfword add clamps each lane
// - Quad byte add clamps each lane
// - Dual halfword subtract clamps each lane
// - Quad byte subtract clamps each lane
// - Pack: low from first, high shifted
// - Pack: high from first, low arith-shifted
// - Extensions rotate right by 0/8/16/24
// - Byte or halfword field sign/zero extended
// - Dual byte: bits 7..0, 23..16 extended
// - Accumulate forms add to word or halves
// - Extensions leave flags unchanged
// - Flag sticky until status write clears
module spx_alu
  import spx_alu_pkg::*;
#(
  parameter int WIDTH = SPX_WORD_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Issue
  input wire logic i_valid,
  input wire spx_op_type i_op,
  input wire logic [31:0] i_op_a,
  input wire logic [31:0] i_op_b,
  input wire logic [4:0] i_shift_amt,
  input wire logic [1:0] i_rotate_sel,
  // Status register write
  input wire logic i_status_register_write,
  input wire logic i_sat_flag_wdata,
  // Result
  output logic o_valid,
  output logic [31:0] o_result,
  output logic o_sat_flag
);

  logic valid_reg;
  logic [31:0] result_reg;
  logic sat_flag_reg;
  logic [31:0] result_next;
  logic sat_flag_next;

  // Signed 33-bit arithmetic so each clamp sees the true value
  wire logic signed [32:0] dbl_full = {i_op_b[31], i_op_b} + {i_op_b[31], i_op_b};
  wire logic dbl_sat = dbl_full[32] != dbl_full[31];
  wire logic [31:0] dbl_val = !dbl_sat ? dbl_full[31:0] :
    (dbl_full[32] ? SPX_SMIN : SPX_SMAX);
  wire logic is_sub = i_op == sat_double_sub_op;
  wire logic [32:0] dbl_ext = {dbl_val[31], dbl_val};
  wire logic [32:0] acc_full = is_sub ? {i_op_a[31], i_op_a} - dbl_ext
                                      : {i_op_a[31], i_op_a} + dbl_ext;
  wire logic acc_sat = acc_full[32] != acc_full[31];
  wire logic [31:0] acc_val = !acc_sat ? acc_full[31:0] :
    (acc_full[32] ? SPX_SMIN : SPX_SMAX);

  // Unsigned lanes, one generate per lane
  logic [31:0] hadd;
  logic [31:0] hsub;
  logic [31:0] badd;
  logic [31:0] bsub;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_half
      wire logic [16:0] s = {1'b0, i_op_a[16*g+:16]} + {1'b0, i_op_b[16*g+:16]};
      wire logic [16:0] d = {1'b0, i_op_a[16*g+:16]} - {1'b0, i_op_b[16*g+:16]};
      assign hadd[16*g+:16] = s[16] ? 16'hFFFF : s[15:0];
      assign hsub[16*g+:16] = d[16] ? 16'h0000 : d[15:0];
    end
    for (g = 0; g < 4; g++) begin : g_byte
      wire logic [8:0] s = {1'b0, i_op_a[8*g+:8]} + {1'b0, i_op_b[8*g+:8]};
      wire logic [8:0] d = {1'b0, i_op_a[8*g+:8]} - {1'b0, i_op_b[8*g+:8]};
      assign badd[8*g+:8] = s[8] ? 8'hFF : s[7:0];
      assign bsub[8*g+:8] = d[8] ? 8'h00 : d[7:0];
    end
  endgenerate

  // Exchange forms: low of a with high of b, high of a with low of b
  wire logic [16:0] x_sum = {1'b0, i_op_a[15:0]} + {1'b0, i_op_b[31:16]};
  wire logic [16:0] x_dif = {1'b0, i_op_a[31:16]} - {1'b0, i_op_b[15:0]};
  wire logic [15:0] x_sum_sat = x_sum[16] ? 16'hFFFF : x_sum[15:0];
  wire logic [15:0] x_dif_sat = x_dif[16] ? 16'h0000 : x_dif[15:0];
  wire logic [31:0] asx_val = {x_sum_sat, x_dif_sat};
  wire logic [31:0] sax_val = {x_dif_sat, x_sum_sat};

  // Pack; the top-low form shifts arithmetically so sign fills from the left
  wire logic [31:0] shl_b = i_op_b << i_shift_amt;
  wire logic [31:0] asr_b = $signed(i_op_b) >>> i_shift_amt;
  wire logic [31:0] pkbt_val = {shl_b[31:16], i_op_a[15:0]};
  wire logic [31:0] pktb_val = {i_op_a[31:16], asr_b[15:0]};

  // Extension: rotate by whole bytes only, 00 means none
  wire logic [4:0] rot_amt = {i_rotate_sel, 3'b000};
  wire logic [31:0] rot_b = (i_op_b >> rot_amt) | (i_op_b << (6'd32 - {1'b0, rot_amt}));
  wire logic [31:0] sxb = {{24{rot_b[7]}}, rot_b[7:0]};
  wire logic [31:0] uxb = {24'h000000, rot_b[7:0]};
  wire logic [31:0] sxh = {{16{rot_b[15]}}, rot_b[15:0]};
  wire logic [31:0] uxh = {16'h0000, rot_b[15:0]};
  wire logic [31:0] sxb16 = {{8{rot_b[23]}}, rot_b[23:16], {8{rot_b[7]}}, rot_b[7:0]};
  wire logic [31:0] uxb16 = {8'h00, rot_b[23:16], 8'h00, rot_b[7:0]};

  // Accumulate; dual forms add per halfword with no carry between halves
  logic [31:0] sxb16_acc;
  logic [31:0] uxb16_acc;
  generate
    for (g = 0; g < 2; g++) begin : g_acc
      assign sxb16_acc[16*g+:16] = i_op_a[16*g+:16] + sxb16[16*g+:16];
      assign uxb16_acc[16*g+:16] = i_op_a[16*g+:16] + uxb16[16*g+:16];
    end
  endgenerate
  wire logic [31:0] sxb_acc = i_op_a + sxb;
  wire logic [31:0] uxb_acc = i_op_a + uxb;
  wire logic [31:0] sxh_acc = i_op_a + sxh;
  wire logic [31:0] uxh_acc = i_op_a + uxh;

  wire logic is_double = (i_op == sat_double_add_op) || is_sub;
  wire logic sat_event = i_valid && is_double && (dbl_sat || acc_sat);

  // One-hot decode; a code outside the enum selects nothing and yields zero
  wire logic sel_asx = i_op == usat_add_sub_exchange_op;
  wire logic sel_sax = i_op == usat_sub_add_exchange_op;
  wire logic sel_hadd = i_op == usat_dual_half_add_op;
  wire logic sel_badd = i_op == usat_quad_byte_add_op;
  wire logic sel_hsub = i_op == usat_dual_half_sub_op;
  wire logic sel_bsub = i_op == usat_quad_byte_sub_op;
  wire logic sel_pkbt = i_op == pack_low_high_op;
  wire logic sel_pktb = i_op == pack_high_low_op;
  wire logic sel_sxb = i_op == sign_ext_byte_op;
  wire logic sel_uxb = i_op == zero_ext_byte_op;
  wire logic sel_sxh = i_op == sign_ext_half_op;
  wire logic sel_uxh = i_op == zero_ext_half_op;
  wire logic sel_sxb16 = i_op == sign_ext_dual_byte_op;
  wire logic sel_uxb16 = i_op == zero_ext_dual_byte_op;
  wire logic sel_sxb_acc = i_op == sign_ext_byte_acc_op;
  wire logic sel_uxb_acc = i_op == zero_ext_byte_acc_op;
  wire logic sel_sxh_acc = i_op == sign_ext_half_acc_op;
  wire logic sel_uxh_acc = i_op == zero_ext_half_acc_op;
  wire logic sel_sxb16_acc = i_op == sign_ext_dual_byte_acc_op;
  wire logic sel_uxb16_acc = i_op == zero_ext_dual_byte_acc_op;

  // Flat AND-OR select; the selects are mutually exclusive
  assign result_next = ({32{is_double}} & acc_val)
    | ({32{sel_asx}} & asx_val)
    | ({32{sel_sax}} & sax_val)
    | ({32{sel_hadd}} & hadd)
    | ({32{sel_badd}} & badd)
    | ({32{sel_hsub}} & hsub)
    | ({32{sel_bsub}} & bsub)
    | ({32{sel_pkbt}} & pkbt_val)
    | ({32{sel_pktb}} & pktb_val)
    | ({32{sel_sxb}} & sxb)
    | ({32{sel_uxb}} & uxb)
    | ({32{sel_sxh}} & sxh)
    | ({32{sel_uxh}} & uxh)
    | ({32{sel_sxb16}} & sxb16)
    | ({32{sel_uxb16}} & uxb16)
    | ({32{sel_sxb_acc}} & sxb_acc)
    | ({32{sel_uxb_acc}} & uxb_acc)
    | ({32{sel_sxh_acc}} & sxh_acc)
    | ({32{sel_uxh_acc}} & uxh_acc)
    | ({32{sel_sxb16_acc}} & sxb16_acc)
    | ({32{sel_uxb16_acc}} & uxb16_acc);

  // Saturation wins over a same-cycle software clear so no event is lost
  wire logic flag_kept = i_status_register_write ? i_sat_flag_wdata
    : sat_flag_reg;
  assign sat_flag_next = sat_event || flag_kept;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      valid_reg <= 1'b0;
      result_reg <= SPX_RESULT_RST;
      sat_flag_reg <= SPX_SAT_FLAG_RST;
    end else if (i_ce) begin
      valid_reg <= i_valid;
      sat_flag_reg <= sat_flag_next;
      if (i_valid) begin
        result_reg <= result_next;
      end
    end
  end

  assign o_valid = valid_reg;
  assign o_result = result_reg;
  assign o_sat_flag = sat_flag_reg;

endmodule

// ==== test/spx_alu_chk.sv ====
`timescale 1ns/1ns
module spx_alu_chk
  import spx_alu_pkg::*;
(
  // Watched ports
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire spx_op_type i_op,
  input wire logic [31:0] i_op_a,
  input wire logic [31:0] i_op_b,
  input wire logic i_status_register_write,
  input wire logic i_sat_flag_wdata,
  input wire logic o_valid,
  input wire logic [31:0] o_result,
  input wire logic o_sat_flag
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  wire logic go = i_ce && i_valid;
  wire logic dbl = go && (i_op == sat_double_add_op || i_op == sat_double_sub_op);
  // Status writes excluded: a clear may land on the same edge
  wire logic hold = go && !dbl && !i_status_register_write;
  chk_issue_answer: assert property (go |=> o_valid)
    else $error("no result one cycle after issue");
  chk_double_sat: assert property (dbl && (i_op_b[31] != i_op_b[30]) |=> o_sat_flag)
    else $error("doubling clamp left flag clear");
  chk_flag_keep: assert property (hold |=> $stable(o_sat_flag))
    else $error("flag moved on a non-double op");
  chk_ext_flag: assert property (hold && i_op >= sign_ext_byte_op |=>
    o_sat_flag == $past(o_sat_flag))
    else $error("flag moved on an extension op");
  chk_flag_sticky: assert property (o_sat_flag && !i_status_register_write |=> o_sat_flag)
    else $error("flag dropped without a write");
  chk_flag_clear: assert property (i_ce && i_status_register_write && !i_sat_flag_wdata
    && !dbl |=> !o_sat_flag)
    else $error("flag not cleared by write");
  chk_half_floor: assert property (go && i_op == usat_dual_half_sub_op |=>
    o_result[31:16] <= $past(i_op_a[31:16]) && o_result[15:0] <= $past(i_op_a[15:0]))
    else $error("halfword difference above minuend");
  chk_pack_low: assert property (go && i_op == pack_low_high_op |=>
    o_result[15:0] == $past(i_op_a[15:0]))
    else $error("pack low half not from first operand");
  chk_freeze_hold: assert property (!i_ce |=>
    $stable(o_valid) && $stable(o_result) && $stable(o_sat_flag))
    else $error("state moved while clock enable was low");
endmodule
bind spx_alu spx_alu_chk spx_alu_chk_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
  .i_valid(i_valid), .i_op(i_op), .i_op_a(i_op_a), .i_op_b(i_op_b),
  .i_status_register_write(i_status_register_write), .i_sat_flag_wdata(i_sat_flag_wdata),
  .o_valid(o_valid), .o_result(o_result), .o_sat_flag(o_sat_flag));

// ==== test/spx_issue.sv ====
`timescale 1ns/1ns
module spx_issue
  import spx_alu_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Issue side
  output logic o_nrst,
  output logic o_vld,
  output spx_op_type o_op,
  output logic [31:0] o_a,
  output logic [31:0] o_b,
  output logic [4:0] o_sh,
  output logic [1:0] o_rot,
  output logic o_wr,
  output logic o_wd,
  output logic o_ce
);
  initial begin
    {o_nrst, o_vld, o_a, o_b, o_sh, o_rot, o_wr, o_wd} = '0;
    o_op = sat_double_add_op;
    o_ce = 1'b1;
  end
  // Mid-run, wait for an edge so reset also changes on the clock
  task automatic reset_pulse;
    if (o_nrst) @(posedge i_clk);
    o_nrst <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_nrst <= 1'b1;
  endtask
  // Op and flag clear in one cycle, with a chosen clock enable
  task automatic issue_wr(input spx_op_type op, input logic [31:0] a, b, input logic ce);
    @(posedge i_clk);
    o_vld <= 1'b1;
    o_op <= op;
    o_a <= a;
    o_b <= b;
    o_wr <= 1'b1;
    o_wd <= 1'b0;
    o_ce <= ce;
    @(posedge i_clk);
    o_vld <= 1'b0;
    o_wr <= 1'b0;
    o_ce <= 1'b1;
  endtask
  // Idle cycle after each op so nothing executes twice
  task automatic issue(input spx_op_type op, input logic [31:0] a, b, input logic [4:0] sh,
    input logic [1:0] rot);
    @(posedge i_clk);
    o_vld <= 1'b1;
    o_op <= op;
    o_a <= a;
    o_b <= b;
    o_sh <= sh;
    o_rot <= rot;
    @(posedge i_clk);
    o_vld <= 1'b0;
  endtask
  task automatic swr(input logic d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_wd <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
endmodule

// ==== test/spx_alu_tb.sv ====
`timescale 1ns/1ns
module spx_alu_tb;
  import spx_alu_pkg::*;
  logic clk, nrst, vld, wr, wd, ce, res_vld, flag, flg;
  spx_op_type op;
  logic [31:0] a, b, res;
  logic [4:0] sh, sh_v;
  logic [1:0] rot, rot_v;
  int error_cnt = 0;
  int comparisons = 0;
  spx_issue spx_issue_i (.i_clk(clk), .o_nrst(nrst), .o_vld(vld), .o_op(op), .o_a(a),
    .o_b(b), .o_sh(sh), .o_rot(rot), .o_wr(wr), .o_wd(wd), .o_ce(ce));
  spx_alu spx_alu_i (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_valid(vld), .i_op(op),
    .i_op_a(a), .i_op_b(b), .i_shift_amt(sh), .i_rotate_sel(rot),
    .i_status_register_write(wr), .i_sat_flag_wdata(wd), .o_valid(res_vld),
    .o_result(res), .o_sat_flag(flag));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cmp(input logic v, input logic [31:0] r);
    #1;
    comparisons++;
    if (res_vld !== v || res !== r || flag !== flg) begin
      error_cnt++;
      $display("BAD t=%0t got %h %h %h exp %h %h %h", $time, res_vld, res, flag, v, r, flg);
    end
  endtask
  task automatic go(input spx_op_type o, input logic [31:0] x, y, r);
    spx_issue_i.issue(o, x, y, sh_v, rot_v);
    cmp(1'b1, r);
  endtask
  // Extension source fixed so each rotate picks a different lane
  task automatic ex(input spx_op_type o, input logic [1:0] rt, input logic [31:0] x, r);
    rot_v = rt;
    go(o, x, 32'h81807F01, r);
  endtask
  task automatic t_double;
    go(sat_double_add_op, 32'h5, 32'h3, 32'hB);
    flg = 1'b1;
    go(sat_double_add_op, 32'h1, 32'h40000000, 32'h7FFFFFFF);
    spx_issue_i.swr(1'b0);
    flg = 1'b0;
    cmp(1'b0, 32'h7FFFFFFF);
    go(sat_double_sub_op, 32'hA, 32'h3, 32'h4);
    flg = 1'b1;
    go(sat_double_sub_op, 32'h80000000, 32'h1, 32'h80000000);
  endtask
  task automatic t_usat;
    go(usat_add_sub_exchange_op, 32'h5FFF0, 32'h200010, 32'hFFFF0000);
    go(usat_sub_add_exchange_op, 32'h5FFF0, 32'h200010, 32'hFFFF);
    go(usat_dual_half_add_op, 32'hFFF00001, 32'h200002, 32'hFFFF0003);
    go(usat_quad_byte_add_op, 32'hF0108001, 32'h20108002, 32'hFF20FF03);
    go(usat_dual_half_sub_op, 32'h108000, 32'h200001, 32'h7FFF);
    go(usat_quad_byte_sub_op, 32'h105000FF, 32'h20100101, 32'h4000FE);
    sh_v = 5'h10;
    go(pack_low_high_op, 32'h11112222, 32'hABCD, 32'hABCD2222);
    go(pack_high_low_op, 32'h11112222, 32'h80000000, 32'h11118000);
  endtask
  task automatic t_ext;
    ex(sign_ext_byte_op, 2'h1, 32'h0, 32'h7F);
    ex(zero_ext_byte_op, 2'h2, 32'h0, 32'h80);
    ex(sign_ext_half_op, 2'h2, 32'h0, 32'hFFFF8180);
    ex(zero_ext_half_op, 2'h3, 32'h0, 32'h181);
    ex(sign_ext_dual_byte_op, 2'h0, 32'h0, 32'hFF800001);
    ex(zero_ext_dual_byte_op, 2'h1, 32'h0, 32'h81007F);
    ex(sign_ext_byte_acc_op, 2'h3, 32'h10001, 32'hFF82);
    ex(zero_ext_byte_acc_op, 2'h0, 32'h10001, 32'h10002);
    ex(sign_ext_half_acc_op, 2'h1, 32'h10001, 32'h8080);
    ex(zero_ext_half_acc_op, 2'h2, 32'h10001, 32'h18181);
    ex(sign_ext_dual_byte_acc_op, 2'h2, 32'h10001, 32'h2FF81);
    ex(zero_ext_dual_byte_acc_op, 2'h3, 32'h10001, 32'h800082);
  endtask
  // Clear racing a clamp, a frozen op and clear, then reset mid-run
  task automatic t_corner;
    spx_issue_i.issue_wr(sat_double_add_op, 32'h1, 32'h40000000, 1'b1);
    cmp(1'b1, 32'h7FFFFFFF);
    spx_issue_i.issue_wr(zero_ext_byte_op, 32'h0, 32'h12, 1'b0);
    cmp(1'b0, 32'h7FFFFFFF);
    flg = 1'b0;
    spx_issue_i.reset_pulse;
    cmp(1'b0, 32'h0);
  endtask
  task automatic stop_test;
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {flg, sh_v, rot_v} = '0;
    spx_issue_i.reset_pulse;
    cmp(1'b0, 32'h0);
    t_double;
    t_usat;
    t_ext;
    t_corner;
    stop_test;
  end
endmodule
